// ### rtl/quad_enc_pkg.sv
// Package with register map, field positions and bus carrier of the quadrature encoder.
// Notes on behaviour
// - Sixteen-bit counter steps on every edge where only one phase moves.
// - Phase and marker pins synchronized before use.
// - Invert bit swaps phase pins onto counter.
// - A leading B counts up, else down.
// - Reset clears the invert bit.
// - Status bit 1 shows counting direction.
// - Status bit 2 set until limit written.
// - Marker resets counter to zero or limit.
// - Marker reset waits for next phase edge.
// - Later marker resets align to first edge.
// - Marker rising forward, falling in reverse.
// - Without marker mode counter wraps at limit.
// - Reset clears marker reset enable.
// - First-marker mode resets only once, flags it.
// - Check count at marker, flag and interrupt.
// - Status shows synchronized pin levels.
// - Loop timer runs only while enabled.
// - Timer decrements every prescale plus one cycles.
// - Timer at zero interrupts and reloads period.
// - Capture on timer expiry or count read.
// - Control bit 2 first-marker, status bit 6.
// - Control bit 3 checking, status bit 0.
// - Status bits 3,4,5 give A,B,marker levels.
// - Control bit 4 selects capture event.
package quad_enc_pkg;
   localparam int CW = 16;
   localparam logic [3:0] OFS_STATUS    = 4'h0;
   localparam logic [3:0] OFS_MAX_COUNT = 4'h1;
   localparam logic [3:0] OFS_CONTROL   = 4'h2;
   localparam logic [3:0] OFS_POSITION  = 4'h3;
   localparam logic [3:0] OFS_TIMER     = 4'h4;
   localparam logic [3:0] OFS_PERIOD    = 4'h5;
   localparam logic [3:0] OFS_PRESCALE  = 4'h6;
   localparam logic [3:0] OFS_CAP_COUNT = 4'h7;
   localparam logic [3:0] OFS_CAP_INTVL = 4'h8;
   localparam logic [3:0] OFS_CAP_ELAPS = 4'h9;
   localparam int CTL_INVERT = 0;
   localparam int CTL_MARKER = 1;
   localparam int CTL_FIRST  = 2;
   localparam int CTL_CHECK  = 3;
   localparam int CTL_CAPSEL = 4;
   localparam int CTL_TIMER  = 5;
   localparam int ST_ERROR  = 0;
   localparam int ST_UP     = 1;
   localparam int ST_UNINIT = 2;
   localparam int ST_PIN_A  = 3;
   localparam int ST_PIN_B  = 4;
   localparam int ST_PIN_Z  = 5;
   localparam int ST_FIRST  = 6;
   localparam logic [5:0]  CONTROL_RST  = 6'h00;
   localparam logic [15:0] MAX_RST      = 16'hFFFF;
   localparam logic [15:0] WORD_RST     = 16'h0000;
   localparam logic [7:0]  PRESCALE_RST = 8'h00;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;
endpackage

// ### rtl/quad_encoder.sv
// Quadrature encoder counter with marker reset, count checking and loop timer.
module quad_encoder (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_encoder_phase_a_pin,
   input  wire logic                   i_encoder_phase_b_pin,
   input  wire logic                   i_marker_pin,
   input  wire quad_enc_pkg::bus_req_t i_bus,
   input  wire logic [15:0]            i_interval_time,
   input  wire logic [15:0]            i_elapsed_time,
   output logic [15:0]                 o_rdata,
   output logic                        o_irq
);
   import quad_enc_pkg::*;

   logic [2:0]  meta_reg;
   logic [2:0]  sync_reg;
   logic        prev_a_reg;
   logic        prev_b_reg;
   logic        prev_z_reg;
   logic [5:0]  control_reg;
   logic [15:0] max_count_reg;
   logic [15:0] count_reg;
   logic [15:0] timer_reg;
   logic [15:0] period_reg;
   logic [7:0]  scale_reg;
   logic [7:0]  presc_reg;
   logic [15:0] cap_count_reg;
   logic [15:0] cap_intvl_reg;
   logic [15:0] cap_elaps_reg;
   logic        dir_reg;
   logic        uninit_reg;
   logic        error_reg;
   logic        first_seen_reg;
   logic        pend_reg;
   logic        aligned_reg;
   logic        rec_phase_reg;
   logic        rec_level_reg;
   logic [15:0] rdata_reg;
   logic        irq_reg;
   logic [2:0]  warm_reg;

   logic        ready;
   logic        a_cur;
   logic        b_cur;
   logic        a_chg;
   logic        b_chg;
   logic        q_edge;
   logic        up_now;
   logic        edge_level;
   logic        norm_level;
   logic        z_rise;
   logic        z_fall;
   logic        marker_seen;
   logic        align_ok;
   logic        apply;
   logic        do_reset;
   logic        mismatch;
   logic        err_event;
   logic        tick;
   logic        expire;
   logic [15:0] natural_next;
   logic [15:0] expected;
   logic [15:0] count_next;

   // Next count with wrap at the limit in both directions.
   function automatic logic [15:0] step_count(input logic [15:0] cnt, input logic up,
                                              input logic [15:0] lim);
      if (up) begin
         step_count = (cnt == lim) ? 16'h0000 : 16'(cnt + 16'h0001);
      end else begin
         step_count = (cnt == 16'h0000) ? lim : 16'(cnt - 16'h0001);
      end
   endfunction

   function automatic logic wr_at(input bus_req_t b, input logic [3:0] ofs);
      wr_at = b.wr && (b.addr == ofs);
   endfunction

   // Two flops per pin; only the second stage feeds any logic.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
      end else begin
         meta_reg <= {i_marker_pin, i_encoder_phase_b_pin, i_encoder_phase_a_pin};
         sync_reg <= meta_reg;
      end
   end

   // Edges are ignored until the synchronizers and the previous-level flops hold pin data.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         warm_reg <= 3'h0;
      end else begin
         warm_reg <= {warm_reg[1:0], 1'b1};
      end
   end

   always_comb begin
      ready = warm_reg[2];
      a_cur = control_reg[CTL_INVERT] ? sync_reg[1] : sync_reg[0];
      b_cur = control_reg[CTL_INVERT] ? sync_reg[0] : sync_reg[1];
      a_chg = a_cur ^ prev_a_reg;
      b_chg = b_cur ^ prev_b_reg;
      // A step with both phases moving at once is ambiguous and is dropped.
      q_edge = (a_chg ^ b_chg) & ready;
      up_now = a_cur ^ prev_b_reg;
      edge_level = a_chg ? a_cur : b_cur;
      // Edge polarity expressed as if moving forward, so reverse uses the opposite one.
      norm_level = edge_level ^ ~up_now;
      z_rise = sync_reg[2] & ~prev_z_reg & ready;
      z_fall = ~sync_reg[2] & prev_z_reg & ready;
      marker_seen = control_reg[CTL_MARKER] & (dir_reg ? z_rise : z_fall);
      align_ok = ~aligned_reg | ((b_chg == rec_phase_reg) && (norm_level == rec_level_reg));
      apply = q_edge & pend_reg & align_ok;
      do_reset = apply & (~control_reg[CTL_FIRST] | ~aligned_reg);
      natural_next = step_count(count_reg, up_now, max_count_reg);
      expected = up_now ? 16'h0000 : max_count_reg;
      mismatch = natural_next != expected;
      err_event = apply & control_reg[CTL_CHECK] & mismatch;
      count_next = do_reset ? expected : natural_next;
      tick = control_reg[CTL_TIMER] && (presc_reg == scale_reg);
      expire = tick && (timer_reg == 16'h0000);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_a_reg <= 1'b0;
         prev_b_reg <= 1'b0;
         prev_z_reg <= 1'b0;
      end else begin
         prev_a_reg <= a_cur;
         prev_b_reg <= b_cur;
         prev_z_reg <= sync_reg[2];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         control_reg <= CONTROL_RST;
      end else if (wr_at(i_bus, OFS_CONTROL)) begin
         control_reg <= i_bus.wdata[5:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         max_count_reg <= MAX_RST;
         uninit_reg    <= 1'b1;
      end else if (wr_at(i_bus, OFS_MAX_COUNT)) begin
         max_count_reg <= i_bus.wdata;
         uninit_reg    <= 1'b0;
      end
   end

   // A software write to the count takes priority over a coincident edge.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count_reg <= WORD_RST;
      end else if (wr_at(i_bus, OFS_POSITION)) begin
         count_reg <= i_bus.wdata;
      end else if (q_edge) begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         dir_reg <= 1'b1;
      end else if (q_edge) begin
         dir_reg <= up_now;
      end
   end

   // A marker stays pending until the qualifying phase edge; a new marker wins over the clear.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pend_reg <= 1'b0;
      end else begin
         pend_reg <= control_reg[CTL_MARKER] & (marker_seen | (pend_reg & ~apply));
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aligned_reg   <= 1'b0;
         rec_phase_reg <= 1'b0;
         rec_level_reg <= 1'b0;
      end else if (apply && !aligned_reg) begin
         aligned_reg   <= 1'b1;
         rec_phase_reg <= b_chg;
         rec_level_reg <= norm_level;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         first_seen_reg <= 1'b0;
      end else if (marker_seen) begin
         first_seen_reg <= 1'b1;
      end
   end

   // The error flag follows each checked marker; counting carries on regardless.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         error_reg <= 1'b0;
      end else if (apply && control_reg[CTL_CHECK]) begin
         error_reg <= mismatch;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         presc_reg <= PRESCALE_RST;
      end else if (!control_reg[CTL_TIMER] || tick) begin
         presc_reg <= 8'h00;
      end else begin
         presc_reg <= 8'(presc_reg + 8'h01);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         timer_reg <= WORD_RST;
      end else if (wr_at(i_bus, OFS_TIMER)) begin
         timer_reg <= i_bus.wdata;
      end else if (expire) begin
         timer_reg <= period_reg;
      end else if (tick) begin
         timer_reg <= 16'(timer_reg - 16'h0001);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         period_reg <= WORD_RST;
         scale_reg  <= PRESCALE_RST;
      end else begin
         if (wr_at(i_bus, OFS_PERIOD)) begin
            period_reg <= i_bus.wdata;
         end
         if (wr_at(i_bus, OFS_PRESCALE)) begin
            scale_reg <= i_bus.wdata[7:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cap_count_reg <= WORD_RST;
         cap_intvl_reg <= WORD_RST;
         cap_elaps_reg <= WORD_RST;
      end else if (control_reg[CTL_CAPSEL]) begin
         if (expire) begin
            cap_count_reg <= count_reg;
            cap_intvl_reg <= i_interval_time;
            cap_elaps_reg <= i_elapsed_time;
         end
      end else if (i_bus.rd && (i_bus.addr == OFS_POSITION)) begin
         cap_intvl_reg <= i_interval_time;
         cap_elaps_reg <= i_elapsed_time;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= expire | err_event;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_reg <= WORD_RST;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            OFS_STATUS:    rdata_reg <= {9'h000, first_seen_reg, sync_reg,
                                         uninit_reg, dir_reg, error_reg};
            OFS_MAX_COUNT: rdata_reg <= max_count_reg;
            OFS_CONTROL:   rdata_reg <= {10'h000, control_reg};
            OFS_POSITION:  rdata_reg <= count_reg;
            OFS_TIMER:     rdata_reg <= timer_reg;
            OFS_PERIOD:    rdata_reg <= period_reg;
            OFS_PRESCALE:  rdata_reg <= {8'h00, scale_reg};
            OFS_CAP_COUNT: rdata_reg <= cap_count_reg;
            OFS_CAP_INTVL: rdata_reg <= cap_intvl_reg;
            OFS_CAP_ELAPS: rdata_reg <= cap_elaps_reg;
            default:       rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_irq   = irq_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   logic [2:0] pins_now;
   assign pins_now = {i_marker_pin, i_encoder_phase_b_pin, i_encoder_phase_a_pin};

   sequence s_tick;
      tick && scale_reg == 8'h02;
   endsequence
   sequence s_hold_scale;
      (control_reg[CTL_TIMER] && scale_reg == 8'h02 && !i_bus.wr)[*3];
   endsequence

   AST_SYNC_DELAY:
      assert property ($past(i_rst_n) && $past(i_rst_n, 2) |-> sync_reg == $past(pins_now, 2))
      else $error("pin level did not arrive after two stages");
   AST_PIN_STATUS:
      assert property (i_bus.rd && i_bus.addr == OFS_STATUS |=> o_rdata[5:3] == $past(sync_reg))
      else $error("status pin bits differ from synchronized levels");
   AST_COUNT_UP:
      assert property (q_edge && up_now && !do_reset && !i_bus.wr && count_reg != max_count_reg
                       |=> count_reg == 16'($past(count_reg) + 16'h0001))
      else $error("forward edge did not increment count");
   AST_COUNT_WRAP_DOWN:
      assert property (q_edge && !up_now && !do_reset && !i_bus.wr && count_reg == 16'h0000
                       |=> count_reg == $past(max_count_reg))
      else $error("reverse wrap below zero did not load limit");
   AST_DIR_STATUS:
      assert property (q_edge ##1 (i_bus.rd && i_bus.addr == OFS_STATUS)
                       |=> o_rdata[ST_UP] == $past(up_now, 2))
      else $error("direction status does not follow last edge");
   AST_UNINIT_CLEAR:
      assert property (wr_at(i_bus, OFS_MAX_COUNT) |=> !uninit_reg ##1 !uninit_reg)
      else $error("uninitialized flag survived limit write");
   AST_RESET_DEFAULTS:
      assert property ($past(!i_rst_n) |-> control_reg == CONTROL_RST && uninit_reg)
      else $error("control not cleared by reset");
   AST_MARKER_RESET_FWD:
      assert property (apply && up_now && !aligned_reg && !i_bus.wr |=> count_reg == 16'h0000)
      else $error("first forward marker reset did not clear count");
   AST_MARKER_OFF:
      assert property (!control_reg[CTL_MARKER] |=> !pend_reg)
      else $error("marker pending while marker mode is off");
   AST_PRESCALE_SPACING:
      assert property (s_tick ##1 s_hold_scale |-> tick)
      else $error("timer step spacing differs from prescale plus one");
   AST_TIMER_HOLD:
      assert property (!control_reg[CTL_TIMER] && !i_bus.wr |=> $stable(timer_reg))
      else $error("loop timer moved while disabled");
   AST_TIMER_EXPIRE:
      assert property (expire && !i_bus.wr |=> timer_reg == $past(period_reg) && o_irq)
      else $error("timer expiry did not reload and interrupt");
   AST_ERROR_FLAG:
      assert property (err_event |=> error_reg && o_irq)
      else $error("count mismatch not flagged");
   AST_READ_CAPTURE:
      assert property (i_bus.rd && i_bus.addr == OFS_POSITION && !control_reg[CTL_CAPSEL]
                       |=> cap_intvl_reg == $past(i_interval_time))
      else $error("count read did not capture interval");
   AST_SETTLE_QUIET:
      assert property ($rose(i_rst_n) |-> !q_edge ##1 !q_edge ##1 !q_edge)
      else $error("phase edge counted before synchronizers settled");
   AST_MARKER_RECOGNIZE:
      assert property (control_reg[CTL_MARKER] && (dir_reg ? z_rise : z_fall)
                       |=> pend_reg && first_seen_reg)
      else $error("marker edge of the moving direction not recognized");
   AST_PEND_HOLD:
      assert property (pend_reg && !q_edge && control_reg[CTL_MARKER] |=> pend_reg)
      else $error("pending marker dropped without a phase edge");
   AST_FIRST_ONLY:
      assert property (apply && aligned_reg && control_reg[CTL_FIRST] && !i_bus.wr
                       |=> count_reg == $past(natural_next))
      else $error("first-marker mode reset the count again");
endmodule

// ### test/enc_model.sv
// Behavioural incremental encoder with quadrature phases and a zero marker.
module enc_model (
   input  wire logic i_clk,
   output logic      o_a,
   output logic      o_b,
   output logic      o_z
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph;
   initial begin
      ph = 2'h0;
      o_a = 1'b0;
      o_b = 1'b0;
      o_z = 1'b0;
   end
   // Phase index walks 00,10,11,01 (A,B) upwards, so A leads B when stepping forward.
   task automatic step(input logic fwd);
      repeat (4) @(posedge i_clk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      o_a <= ph[1] ^ ph[0];
      o_b <= ph[1];
      repeat (4) @(posedge i_clk);
   endtask
   task automatic mark(input logic v);
      repeat (4) @(posedge i_clk);
      o_z <= v;
      repeat (4) @(posedge i_clk);
   endtask
endmodule

// ### test/test_quad_encoder.sv
// Self-checking bench for the quadrature encoder driven by a behavioural encoder.
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_quad_encoder;
   timeunit 1ns;
   timeprecision 1ps;
   import quad_enc_pkg::*;
   logic        i_clk;
   logic        i_rst_n;
   wire         pa, pb, pz;
   bus_req_t    bus;
   logic [15:0] ivl, els, o_rdata;
   logic        o_irq;
   logic        rd_seen = 1'b0;
   logic        roll = 1'b1;
   logic [15:0] q[$];
   logic [31:0] lfsr = 97152;
   int          num_errors = 0, n_tests = 0, cyc = 0, irq_cnt = 0, irq_t = 0, irq_gap = 0;

   quad_encoder quad_encoder_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_encoder_phase_a_pin(pa),
      .i_encoder_phase_b_pin(pb), .i_marker_pin(pz), .i_bus(bus), .i_interval_time(ivl),
      .i_elapsed_time(els), .o_rdata(o_rdata), .o_irq(o_irq));
   enc_model enc_model_i (.i_clk(i_clk), .o_a(pa), .o_b(pb), .o_z(pz));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected status word built from the pin levels the model is driving.
   function automatic logic [15:0] st(input logic ui, up, e, f);
      return {9'h000, f, pz, pb, pa, ui, up, e};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk);
      bus <= '{a, d, 1'b0, 1'b0};
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      q.push_back(e);
      @(posedge i_clk);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge i_clk);
      bus <= '{a, 16'h0000, 1'b0, 1'b0};
   endtask
   task automatic steps(input int n, input logic fwd);
      repeat (n) enc_model_i.step(fwd);
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Read data stand only in the cycle after the read strobe.
   always @(posedge i_clk) begin
      rd_seen <= bus.rd;
      cyc <= cyc + 1;
      if (roll) begin
         lfsr <= nxt(lfsr);
         ivl <= lfsr[15:0];
         els <= lfsr[31:16];
      end
      if (o_irq === 1'b1) begin
         irq_gap <= cyc - irq_t;
         irq_t <= cyc;
         irq_cnt <= irq_cnt + 1;
      end
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   always @(negedge i_clk) begin
      if (rd_seen === 1'b1) begin
         `CHK(o_rdata, q.pop_front())
      end
   end

   initial begin
      i_rst_n = 1'b0;
      bus = '0;
      ivl = 16'h0000;
      els = 16'h0000;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd(OFS_CONTROL, 16'h0000);
      rd(OFS_STATUS, st(1'b1, 1'b1, 1'b0, 1'b0));
      rd(OFS_MAX_COUNT, 16'hFFFF);
      wr(4'hF, 16'h1234);
      rd(4'hF, 16'h0000);
      wr(OFS_STATUS, 16'h0041);
      wr(OFS_MAX_COUNT, 16'h000F);
      rd(OFS_STATUS, st(1'b0, 1'b1, 1'b0, 1'b0));
      steps(5, 1'b1);
      rd(OFS_POSITION, 16'h0005);
      steps(7, 1'b0);
      rd(OFS_POSITION, 16'h000E);
      rd(OFS_STATUS, st(1'b0, 1'b0, 1'b0, 1'b0));
      steps(3, 1'b1);
      rd(OFS_POSITION, 16'h0001);
      enc_model_i.mark(1'b1);
      steps(1, 1'b1);
      enc_model_i.mark(1'b0);
      rd(OFS_POSITION, 16'h0002);
      wr(OFS_CONTROL, 16'h0001);
      steps(2, 1'b1);
      rd(OFS_POSITION, 16'h0000);
      // Marker reset with checking: the first applied edge sees 6 instead of 0.
      wr(OFS_CONTROL, 16'h000A);
      // A forward step first, so the rising marker edge is the recognized one.
      steps(1, 1'b1);
      wr(OFS_POSITION, 16'h0005);
      enc_model_i.mark(1'b1);
      steps(1, 1'b1);
      enc_model_i.mark(1'b0);
      rd(OFS_POSITION, 16'h0000);
      rd(OFS_STATUS, st(1'b0, 1'b1, 1'b1, 1'b1));
      steps(15, 1'b1);
      enc_model_i.mark(1'b1);
      steps(1, 1'b1);
      rd(OFS_STATUS, st(1'b0, 1'b1, 1'b0, 1'b1));
      rd(OFS_POSITION, 16'h0000);
      steps(1, 1'b0);
      enc_model_i.mark(1'b0);
      steps(4, 1'b0);
      rd(OFS_POSITION, 16'h000F);
      rd(OFS_STATUS, st(1'b0, 1'b0, 1'b1, 1'b1));
      `CHK(irq_cnt, 2)
      roll <= 1'b0;
      wr(OFS_PRESCALE, 16'h0002);
      wr(OFS_PERIOD, 16'h0003);
      wr(OFS_CONTROL, 16'h0030);
      repeat (40) @(posedge i_clk);
      `CHK(irq_gap, 12)
      rd(OFS_CAP_COUNT, 16'h000F);
      rd(OFS_CAP_INTVL, ivl);
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_TIMER, 16'h0007);
      roll <= 1'b1;
      repeat (20) @(posedge i_clk);
      rd(OFS_TIMER, 16'h0007);
      roll <= 1'b0;
      rd(OFS_POSITION, 16'h000F);
      rd(OFS_CAP_ELAPS, els);
      // Mid-run reset with phase A high, then first-marker-only mode.
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd(OFS_STATUS, st(1'b1, 1'b1, 1'b0, 1'b0));
      rd(OFS_POSITION, 16'h0000);
      wr(OFS_MAX_COUNT, 16'h0007);
      wr(OFS_CONTROL, 16'h0006);
      enc_model_i.mark(1'b1);
      steps(1, 1'b1);
      rd(OFS_POSITION, 16'h0000);
      enc_model_i.mark(1'b0);
      steps(3, 1'b1);
      enc_model_i.mark(1'b1);
      steps(1, 1'b1);
      rd(OFS_POSITION, 16'h0004);
      rd(OFS_STATUS, st(1'b0, 1'b1, 1'b0, 1'b1));
      repeat (3) @(posedge i_clk);
      wrap_up();
   end
endmodule
